// *** core/ccmlut_pipeline.v ***
// Color correction matrix followed by a 10-bit level lookup table.
`timescale 1ns/1ps
`include "ccmlut_defs.vh"
// Notes on behaviour
// - Corrected component adds coefficient times difference.
// - Coefficient addressed by row and column selectors.
// - Diagonal fixed one, writes ignored, reads zero.
// - Coefficients span minus one to one, reset zero.
// - Both selectors reset to red.
// - Matrix applies only in three 8-bit formats.
// - Ten-bit level table remaps every pixel.
// - Table applies only when enabled; reset disabled.
// - Index selects entry; value writes and reads it.
// - Index and value span 0..1023, reset zero.
// - Component selector reads luminance only.
module ccmlut_pipeline #(
    parameter DW = 10,
    parameter CW = 10
) (
    input  wire          sys_clk,
    input  wire          rst_n,
    input  wire [1:0]    matrix_row_select_wdata,
    input  wire          matrix_row_select_we,
    input  wire [1:0]    matrix_column_select_wdata,
    input  wire          matrix_column_select_we,
    input  wire [CW-1:0] matrix_coefficient_wdata,
    input  wire          matrix_coefficient_we,
    input  wire          table_enable_wdata,
    input  wire          table_enable_we,
    input  wire [DW-1:0] table_entry_index_wdata,
    input  wire          table_entry_index_we,
    input  wire [DW-1:0] table_entry_level_wdata,
    input  wire          table_entry_level_we,
    input  wire [2:0]    output_pixel_format,
    input  wire          pix_valid,
    input  wire [DW-1:0] pix_red,
    input  wire [DW-1:0] pix_green,
    input  wire [DW-1:0] pix_blue,
    output reg  [1:0]    matrix_row_select,
    output reg  [1:0]    matrix_column_select,
    output reg  [CW-1:0] matrix_coefficient,
    output reg           table_enable,
    output reg  [DW-1:0] table_entry_index,
    output reg  [DW-1:0] table_entry_level,
    output reg  [1:0]    table_component_select,
    output reg           out_valid,
    output reg  [DW-1:0] out_red,
    output reg  [DW-1:0] out_green,
    output reg  [DW-1:0] out_blue
);
    // Coefficients are signed with eight fraction bits; 0x100 means one.
    reg  [CW-1:0] coef_reg [0:5];
    reg           s1_valid_reg;
    reg  [DW-1:0] s1_r_reg;
    reg  [DW-1:0] s1_g_reg;
    reg  [DW-1:0] s1_b_reg;
    reg           s2_valid_reg;
    wire [DW-1:0] lut_r;
    wire [DW-1:0] lut_g;
    wire [DW-1:0] lut_b;
    wire [DW-1:0] host_level;
    reg           lvl_hold_reg;
    reg           s2_en_reg;
    reg  [DW-1:0] s2_r_reg;
    reg  [DW-1:0] s2_g_reg;
    reg  [DW-1:0] s2_b_reg;

    // Maps a row and column pair onto one of six off-diagonal slots; 7 marks the diagonal.
    function [2:0] slot_of;
        input [1:0] row;
        input [1:0] col;
        begin
            if (row == col || row > 2'h2 || col > 2'h2) begin
                slot_of = 3'h7;
            end else if (row == `CCMLUT_SEL_RED) begin
                slot_of = (col == `CCMLUT_SEL_GREEN) ? 3'h0 : 3'h1;
            end else if (row == `CCMLUT_SEL_GREEN) begin
                slot_of = (col == `CCMLUT_SEL_RED) ? 3'h2 : 3'h3;
            end else begin
                slot_of = (col == `CCMLUT_SEL_RED) ? 3'h4 : 3'h5;
            end
        end
    endfunction

    // Computes own plus two weighted differences and clips to the level range.
    function [DW-1:0] correct;
        input [DW-1:0] own;
        input [DW-1:0] oth_a;
        input [CW-1:0] k_a;
        input [DW-1:0] oth_b;
        input [CW-1:0] k_b;
        reg signed [DW+CW+3:0] acc;
        begin
            acc = ($signed({2'b00, own}) <<< 8)
                + $signed(k_a) * ($signed({1'b0, oth_a}) - $signed({1'b0, own}))
                + $signed(k_b) * ($signed({1'b0, oth_b}) - $signed({1'b0, own}));
            if (acc < 0) begin
                correct = {DW{1'b0}};
            end else if ((acc >>> 8) > `CCMLUT_LEVEL_MAX) begin
                correct = `CCMLUT_LEVEL_MAX;
            end else begin
                correct = acc[DW+7:8];
            end
        end
    endfunction

    wire [2:0] cur_slot = slot_of(matrix_row_select, matrix_column_select);
    wire       fmt_ok   = output_pixel_format == `CCMLUT_FMT_RGB8 ||
                          output_pixel_format == `CCMLUT_FMT_YUV411 ||
                          output_pixel_format == `CCMLUT_FMT_YUV422;
    wire       coef_ok  = $signed(matrix_coefficient_wdata) <= $signed(`CCMLUT_COEF_ONE) &&
                          $signed(matrix_coefficient_wdata) >= $signed(`CCMLUT_COEF_MONE);
    // A refused selector value must not steer the read-back for a cycle.
    wire       row_take = matrix_row_select_we &&
                          matrix_row_select_wdata <= `CCMLUT_SEL_BLUE;
    wire       col_take = matrix_column_select_we &&
                          matrix_column_select_wdata <= `CCMLUT_SEL_BLUE;
    wire [1:0] row_eff  = row_take ? matrix_row_select_wdata : matrix_row_select;
    wire [1:0] col_eff  = col_take ? matrix_column_select_wdata : matrix_column_select;
    wire [2:0] eff_slot = slot_of(row_eff, col_eff);

    genvar i;
    generate
        for (i = 0; i < 6; i = i + 1) begin : g_coef
            always @(posedge sys_clk or negedge rst_n) begin
                if (!rst_n) begin
                    coef_reg[i] <= {CW{1'b0}};
                end else if (matrix_coefficient_we && coef_ok && cur_slot == i) begin
                    coef_reg[i] <= matrix_coefficient_wdata;
                end
            end
        end
    endgenerate

    // Selector and control registers with their read-back copies.
    always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            matrix_row_select      <= `CCMLUT_SEL_RED;
            matrix_column_select   <= `CCMLUT_SEL_RED;
            matrix_coefficient     <= {CW{1'b0}};
            table_enable           <= 1'b0;
            table_entry_index      <= {DW{1'b0}};
            table_component_select <= `CCMLUT_COMP_LUMA;
        end else begin
            table_component_select <= `CCMLUT_COMP_LUMA;
            if (matrix_row_select_we && matrix_row_select_wdata <= `CCMLUT_SEL_BLUE) begin
                matrix_row_select <= matrix_row_select_wdata;
            end
            if (matrix_column_select_we && matrix_column_select_wdata <= `CCMLUT_SEL_BLUE) begin
                matrix_column_select <= matrix_column_select_wdata;
            end
            if (eff_slot == 3'h7) begin
                matrix_coefficient <= {CW{1'b0}};
            end else if (matrix_coefficient_we && coef_ok && eff_slot == cur_slot) begin
                matrix_coefficient <= matrix_coefficient_wdata;
            end else begin
                matrix_coefficient <= coef_reg[eff_slot];
            end
            if (table_enable_we) begin
                table_enable <= table_enable_wdata;
            end
            if (table_entry_index_we) begin
                table_entry_index <= table_entry_index_wdata;
            end
        end
    end

    // The entry port lags a write by one edge, so the written value is held one extra cycle.
    always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            table_entry_level <= {DW{1'b0}};
            lvl_hold_reg      <= 1'b0;
        end else if (table_entry_level_we) begin
            table_entry_level <= table_entry_level_wdata;
            lvl_hold_reg      <= 1'b1;
        end else if (lvl_hold_reg) begin
            lvl_hold_reg      <= 1'b0;
        end else begin
            table_entry_level <= host_level;
        end
    end

    // Stage one: matrix correction, or a straight copy outside the matrix formats.
    always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            s1_valid_reg <= 1'b0;
            s1_r_reg     <= {DW{1'b0}};
            s1_g_reg     <= {DW{1'b0}};
            s1_b_reg     <= {DW{1'b0}};
        end else begin
            s1_valid_reg <= pix_valid;
            if (fmt_ok) begin
                s1_r_reg <= correct(pix_red, pix_green, coef_reg[0], pix_blue, coef_reg[1]);
                s1_g_reg <= correct(pix_green, pix_red, coef_reg[2], pix_blue, coef_reg[3]);
                s1_b_reg <= correct(pix_blue, pix_red, coef_reg[4], pix_green, coef_reg[5]);
            end else begin
                s1_r_reg <= pix_red;
                s1_g_reg <= pix_green;
                s1_b_reg <= pix_blue;
            end
        end
    end

    // The table is shared by all three components, so each needs its own read port.
    ccmlut_level_table #(.DW(DW)) u_tab_r (
        .sys_clk    (sys_clk),
        .rst_n      (rst_n),
        .wr_en      (table_entry_level_we),
        .wr_index   (table_entry_index),
        .wr_level   (table_entry_level_wdata),
        .rd_index   (s1_r_reg),
        .rd_level   (lut_r),
        .host_index (table_entry_index),
        .host_level (host_level)
    );
    ccmlut_level_table #(.DW(DW)) u_tab_g (
        .sys_clk    (sys_clk),
        .rst_n      (rst_n),
        .wr_en      (table_entry_level_we),
        .wr_index   (table_entry_index),
        .wr_level   (table_entry_level_wdata),
        .rd_index   (s1_g_reg),
        .rd_level   (lut_g),
        .host_index (table_entry_index),
        .host_level ()
    );
    ccmlut_level_table #(.DW(DW)) u_tab_b (
        .sys_clk    (sys_clk),
        .rst_n      (rst_n),
        .wr_en      (table_entry_level_we),
        .wr_index   (table_entry_index),
        .wr_level   (table_entry_level_wdata),
        .rd_index   (s1_b_reg),
        .rd_level   (lut_b),
        .host_index (table_entry_index),
        .host_level ()
    );

    // Stage two holds the pass-through copy alongside the table lookup.
    always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            s2_valid_reg <= 1'b0;
            s2_en_reg    <= 1'b0;
            s2_r_reg     <= {DW{1'b0}};
            s2_g_reg     <= {DW{1'b0}};
            s2_b_reg     <= {DW{1'b0}};
        end else begin
            s2_valid_reg <= s1_valid_reg;
            s2_en_reg    <= table_enable;
            s2_r_reg     <= s1_r_reg;
            s2_g_reg     <= s1_g_reg;
            s2_b_reg     <= s1_b_reg;
        end
    end

    // Stage three: table result when enabled, else the unchanged level.
    always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            out_valid <= 1'b0;
            out_red   <= {DW{1'b0}};
            out_green <= {DW{1'b0}};
            out_blue  <= {DW{1'b0}};
        end else begin
            out_valid <= s2_valid_reg;
            out_red   <= s2_en_reg ? lut_r : s2_r_reg;
            out_green <= s2_en_reg ? lut_g : s2_g_reg;
            out_blue  <= s2_en_reg ? lut_b : s2_b_reg;
        end
    end
endmodule // ccmlut_pipeline

// *** include/ccmlut_defs.vh ***
// Constants for the color matrix and level table pipeline.
`ifndef CCMLUT_DEFS_VH
`define CCMLUT_DEFS_VH
`define CCMLUT_SEL_RED      2'h0
`define CCMLUT_SEL_GREEN    2'h1
`define CCMLUT_SEL_BLUE     2'h2
`define CCMLUT_FMT_RGB8     3'h0
`define CCMLUT_FMT_YUV411   3'h1
`define CCMLUT_FMT_YUV422   3'h2
`define CCMLUT_COMP_LUMA    2'h0
`define CCMLUT_COEF_ONE     10'h100
`define CCMLUT_COEF_MONE    10'h300
`define CCMLUT_LEVEL_MAX    10'h3FF
`endif

// *** core/ccmlut_level_table.v ***
// Level lookup table held in flip-flops with two registered read ports, one for pixels and one for the host.
`timescale 1ns/1ps
`include "ccmlut_defs.vh"
module ccmlut_level_table #(
    parameter DW = 10
) (
    input  wire          sys_clk,
    input  wire          rst_n,
    input  wire          wr_en,
    input  wire [DW-1:0] wr_index,
    input  wire [DW-1:0] wr_level,
    input  wire [DW-1:0] rd_index,
    output reg  [DW-1:0] rd_level,
    input  wire [DW-1:0] host_index,
    output reg  [DW-1:0] host_level
);
    localparam DEPTH = 1 << DW;
    reg [DW-1:0] mem_reg [0:DEPTH-1];
    genvar g;
    generate
        for (g = 0; g < DEPTH; g = g + 1) begin : g_ent
            always @(posedge sys_clk or negedge rst_n) begin
                if (!rst_n) begin
                    mem_reg[g] <= {DW{1'b0}};
                end else if (wr_en && wr_index == g) begin
                    mem_reg[g] <= wr_level;
                end
            end
        end
    endgenerate
    always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            rd_level   <= {DW{1'b0}};
            host_level <= {DW{1'b0}};
        end else begin
            rd_level   <= mem_reg[rd_index];
            host_level <= mem_reg[host_index];
        end
    end
endmodule // ccmlut_level_table

// *** tb/ccmlut_asserts.sv ***
// Port assertions for the color matrix and level table pipeline.
`timescale 1ns/1ps
module ccmlut_asserts #(parameter DW = 10, parameter CW = 10) (
    input wire          sys_clk,
    input wire          rst_n,
    input wire          matrix_row_select_we,
    input wire          table_enable_we,
    input wire          table_enable_wdata,
    input wire          table_entry_index_we,
    input wire [DW-1:0] table_entry_index_wdata,
    input wire [2:0]    output_pixel_format,
    input wire          pix_valid,
    input wire [DW-1:0] pix_red,
    input wire [1:0]    matrix_row_select,
    input wire [1:0]    matrix_column_select,
    input wire [CW-1:0] matrix_coefficient,
    input wire          table_enable,
    input wire [DW-1:0] table_entry_index,
    input wire [1:0]    table_component_select,
    input wire          out_valid,
    input wire [DW-1:0] out_red
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    // Format is sampled in stage one and enable in stage two, so both are held over the whole pipeline.
    sequence s_bypass;
        (pix_valid && output_pixel_format > 3'h2 && !table_enable)
            ##1 (output_pixel_format > 3'h2 && !table_enable) [*3];
    endsequence
    AST_BYPASS: assert property (s_bypass |-> out_valid && out_red == $past(pix_red, 3))
        else $error("bypassed pixel altered");
    AST_LATENCY: assert property (pix_valid |-> ##3 out_valid)
        else $error("output pixel missing");
    AST_NO_SPURIOUS: assert property (out_valid |-> $past(pix_valid, 3))
        else $error("output pixel without input");
    AST_LUMA: assert property (table_component_select == 2'h0)
        else $error("component selector not luminance");
    AST_DIAG: assert property ((matrix_row_select == matrix_column_select) [*3]
        |-> matrix_coefficient == {CW{1'h0}}) else $error("diagonal reads nonzero");
    AST_SPAN: assert property ($signed(matrix_coefficient) >= -256
        && $signed(matrix_coefficient) <= 256) else $error("coefficient out of span");
    AST_SEL: assert property (matrix_row_select != 2'h3 && matrix_column_select != 2'h3)
        else $error("illegal selector");
    AST_ROW_HOLD: assert property (!matrix_row_select_we |=> $stable(matrix_row_select))
        else $error("row selector moved");
    AST_EN_WR: assert property (table_enable_we |=> table_enable == $past(table_enable_wdata))
        else $error("enable not written");
    AST_IDX_WR: assert property (table_entry_index_we
        |=> table_entry_index == $past(table_entry_index_wdata)) else $error("index not written");
endmodule // ccmlut_asserts
bind ccmlut_pipeline ccmlut_asserts #(.DW(DW), .CW(CW)) i_chk (
    .sys_clk, .rst_n, .matrix_row_select_we, .table_enable_we, .table_enable_wdata,
    .table_entry_index_we, .table_entry_index_wdata, .output_pixel_format, .pix_valid,
    .pix_red, .matrix_row_select, .matrix_column_select, .matrix_coefficient, .table_enable,
    .table_entry_index, .table_component_select, .out_valid, .out_red
);

// *** tb/tb.sv ***
// Self-checking bench for the color matrix and level table pipeline.
`timescale 1ns/1ps
`include "ccmlut_defs.vh"
module tb;
    reg         sys_clk, rst_n, pix_valid, table_enable_wdata;
    reg         matrix_row_select_we, matrix_column_select_we, matrix_coefficient_we;
    reg         table_enable_we, table_entry_index_we, table_entry_level_we;
    reg  [1:0]  matrix_row_select_wdata, matrix_column_select_wdata;
    reg  [9:0]  matrix_coefficient_wdata, table_entry_index_wdata, table_entry_level_wdata;
    reg  [9:0]  pix_red, pix_green, pix_blue;
    reg  [2:0]  output_pixel_format;
    wire [1:0]  matrix_row_select, matrix_column_select, table_component_select;
    wire [9:0]  matrix_coefficient, table_entry_index, table_entry_level;
    wire [9:0]  out_red, out_green, out_blue;
    wire        table_enable, out_valid;
    integer     errors, cmp_count, i, en, sel_r, sel_c;
    integer     kc [0:2][0:2];
    reg  [9:0]  lut [0:1023];
    reg  [9:0]  lidx [0:15];
    reg  [31:0] seed;
    ccmlut_pipeline #(.DW(10), .CW(10)) i_dut (
        .sys_clk, .rst_n, .matrix_row_select_wdata, .matrix_row_select_we,
        .matrix_column_select_wdata, .matrix_column_select_we, .matrix_coefficient_wdata,
        .matrix_coefficient_we, .table_enable_wdata, .table_enable_we, .table_entry_index_wdata,
        .table_entry_index_we, .table_entry_level_wdata, .table_entry_level_we,
        .output_pixel_format, .pix_valid, .pix_red, .pix_green, .pix_blue, .matrix_row_select,
        .matrix_column_select, .matrix_coefficient, .table_enable, .table_entry_index,
        .table_entry_level, .table_component_select, .out_valid, .out_red, .out_green, .out_blue
    );
    function [31:0] xs(input [31:0] s);
        reg [31:0] t;
        begin
            t = s ^ (s << 13);
            t = t ^ (t >> 17);
            xs = t ^ (t << 5);
        end
    endfunction
    // Coefficients are kept at -1, 0 or +1 so the expected sum is exact.
    function [9:0] corr(input integer own, input integer a, input integer ka,
                        input integer b, input integer kb);
        integer v;
        begin
            v = own + ka * (a - own) + kb * (b - own);
            corr = (v < 0) ? 10'h000 : (v > 1023) ? 10'h3FF : v[9:0];
        end
    endfunction
    task check(input [9:0] seen, input [9:0] exp);
        begin
            cmp_count = cmp_count + 1;
            if (seen !== exp) begin
                errors = errors + 1;
                $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
            end
        end
    endtask
    task tally_and_finish;
        begin
            $display("errors %0d comparisons %0d", errors, cmp_count);
            if (errors == 0 && cmp_count > 0) begin
                $display("Testbench passed");
            end else begin
                $display("Testbench failed");
            end
            $finish;
        end
    endtask
    task set_coef(input integer r, input integer c, input [9:0] v, input [9:0] exp);
        begin
            @(negedge sys_clk);
            matrix_row_select_wdata = r[1:0];
            matrix_column_select_wdata = c[1:0];
            matrix_row_select_we = 1'h1;
            matrix_column_select_we = 1'h1;
            @(negedge sys_clk);
            {matrix_row_select_we, matrix_column_select_we} = 2'h0;
            matrix_coefficient_wdata = v;
            matrix_coefficient_we = 1'h1;
            repeat (2) @(negedge sys_clk);
            matrix_coefficient_we = 1'h0;
            if (r < 3) sel_r = r;
            if (c < 3) sel_c = c;
            check(matrix_coefficient, exp);
            check({6'h00, matrix_row_select, matrix_column_select},
                  {6'h00, sel_r[1:0], sel_c[1:0]});
        end
    endtask
    task set_entry(input [9:0] idx, input [9:0] v);
        begin
            @(negedge sys_clk);
            table_entry_index_wdata = idx;
            table_entry_index_we = 1'h1;
            @(negedge sys_clk);
            table_entry_index_we = 1'h0;
            table_entry_level_wdata = v;
            table_entry_level_we = 1'h1;
            @(negedge sys_clk);
            table_entry_level_we = 1'h0;
            check(table_entry_level, v);
            @(negedge sys_clk);
            check(table_entry_index, idx);
            check(table_entry_level, v);
        end
    endtask
    task set_enable(input integer v);
        begin
            @(negedge sys_clk);
            table_enable_wdata = v[0];
            table_enable_we = 1'h1;
            @(negedge sys_clk);
            table_enable_we = 1'h0;
            en = v;
            check({9'h000, table_enable}, {9'h000, v[0]});
        end
    endtask
    task run_pix(input integer cnt);
        integer j, n;
        reg [9:0] er, eg, eb;
        begin
            for (j = 0; j < cnt; j = j + 1) begin
                seed = xs(seed);
                @(negedge sys_clk);
                output_pixel_format = seed[2:0];
                pix_red = lidx[seed[6:3]];
                pix_green = lidx[seed[10:7]];
                pix_blue = lidx[seed[14:11]];
                pix_valid = 1'h1;
                {er, eg, eb} = {pix_red, pix_green, pix_blue};
                if (seed[2:0] <= 3'h2) begin
                    er = corr(pix_red, pix_green, kc[0][1], pix_blue, kc[0][2]);
                    eg = corr(pix_green, pix_red, kc[1][0], pix_blue, kc[1][2]);
                    eb = corr(pix_blue, pix_red, kc[2][0], pix_green, kc[2][1]);
                end
                if (en == 1) begin
                    {er, eg, eb} = {lut[er], lut[eg], lut[eb]};
                end
                @(negedge sys_clk);
                pix_valid = 1'h0;
                for (n = 0; n < 8 && out_valid !== 1'h1; n = n + 1) @(negedge sys_clk);
                if (n == 8) begin
                    errors = errors + 1;
                    tally_and_finish;
                end
                check(out_red, er);
                check(out_green, eg);
                check(out_blue, eb);
            end
        end
    endtask
    initial begin
        sys_clk = 1'h0;
        forever #10 sys_clk = ~sys_clk;
    end
    initial begin
        {matrix_row_select_we, matrix_column_select_we, matrix_coefficient_we} = 3'h0;
        {table_enable_we, table_entry_index_we, table_entry_level_we, pix_valid} = 4'h0;
        {matrix_row_select_wdata, matrix_column_select_wdata, table_enable_wdata} = 5'h00;
        {matrix_coefficient_wdata, table_entry_index_wdata, table_entry_level_wdata} = 30'h0;
        {pix_red, pix_green, pix_blue, output_pixel_format} = 33'h0;
        rst_n = 1'h0;
        {errors, cmp_count, en, sel_r, sel_c} = 160'h0;
        seed = 32'hAD96;
        for (i = 0; i < 1024; i = i + 1) lut[i] = 10'h000;
        for (i = 0; i < 16; i = i + 1) begin
            seed = xs(seed);
            lidx[i] = (i == 0) ? 10'h000 : (i == 1) ? 10'h3FF : seed[9:0];
        end
        repeat (20) @(negedge sys_clk);
        rst_n = 1'h1;
        check({3'h0, matrix_row_select, matrix_column_select, table_component_select, table_enable},
              10'h000);
        check(matrix_coefficient, 10'h000);
        check(table_entry_index | table_entry_level, 10'h000);
        for (i = 0; i < 9; i = i + 1) begin
            kc[i / 3][i % 3] = (i / 3 == i % 3) ? 0 : i[0] ? 1 : -1;
            set_coef(i / 3, i % 3, i[0] ? `CCMLUT_COEF_ONE : `CCMLUT_COEF_MONE,
                     (i / 3 == i % 3) ? 10'h000 : i[0] ? `CCMLUT_COEF_ONE : `CCMLUT_COEF_MONE);
        end
        set_coef(0, 1, 10'h101, `CCMLUT_COEF_ONE);
        set_coef(3, 3, 10'h2FF, `CCMLUT_COEF_ONE);
        run_pix(40);
        for (i = 0; i < 16; i = i + 1) begin
            seed = xs(seed);
            set_entry(lidx[i], seed[9:0]);
            lut[lidx[i]] = seed[9:0];
        end
        set_enable(1);
        run_pix(50);
        set_enable(0);
        run_pix(10);
        tally_and_finish;
    end
endmodule // tb
